// >>> rtl/ras_params.svh
`ifndef RAS_PARAMS_SVH
`define RAS_PARAMS_SVH
// program counter, vectors and program memory size
`define PC_W 21
`define RESET_VECTOR 21'h000000
`define VEC_HIGH 21'h000008
`define VEC_LOW 21'h000018
`define PMEM_BYTES_DEF 32768
// stack geometry
`define SP_W 5
`define STACK_DEPTH 31
`define SP_EMPTY 5'h00
`define SP_TOP 5'h1f
// register byte addresses
`define ADDR_PTR 8'h00
`define ADDR_TOPL 8'h04
`define ADDR_TOPH 8'h08
`define ADDR_TOPU 8'h0c
`define ADDR_CFG 8'h10
// pointer and configuration register fields
`define FULL_BIT 7
`define UNF_BIT 6
`define CFG_OVR_BIT 0
`define CFG_RESET 1'b1
`endif

// >>> rtl/ras_pkg.sv
`default_nettype none
package ras_pkg;
	typedef enum logic [2:0]
	{
		OP_NONE,
		OP_PUSH,
		OP_INTACK,
		OP_POP,
		OP_DISCARD
	} stack_op_t;
	typedef enum logic [1:0]
	{
		INT_NONE,
		INT_HIGH,
		INT_LOW
	} int_level_t;
endpackage
`default_nettype wire

// >>> rtl/return_address_stack.sv
`include "ras_params.svh"
`default_nettype none
// Contract
// - program counter is 21 bits, covering a 2 megabyte program space
// - after any reset execution starts at address zero
// - interrupt entry addresses 0x0008 and 0x0018, one per priority level
// - fetch above implemented memory (32 or 16 KB) returns all zeros
// - any mix of calls and interrupts nests up to 31 levels
// - push, call, relative call and interrupt acknowledge push the pc
// - return, return with literal, return from interrupt pop into pc
// - returns never change the pc upper or high latches
// - stack is 31 entries of 21 bits indexed by a 5-bit pointer
// - every reset sets the stack pointer to zero
// - pointer zero has no storage; it marks the empty stack
// - push increments the pointer then writes pc at the new entry
// - pop copies the pointed entry to pc then decrements the pointer
// - stack storage lies outside program and data spaces
// - software reads and writes the pointer and the top entry
// - flags show a push to 31 levels or beyond, or a pop from the empty stack
// - upper, high, low byte registers access the pointed entry directly
// - program and data memory use separate buses
// - 31st push sets full flag; only software, power-on or RSTN_IN clears it
// - with overflow reset, 31st push stores pc+2, flags and resets device
// - without overflow reset pointer stays 31 and later pushes overwrite
// - pop when empty returns zero, sets underflow, pointer stays zero
module return_address_stack
	import ras_pkg::*;
#(
	parameter int PMEM_BYTES = `PMEM_BYTES_DEF
)
(
	// clock and resets
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic POR_IN,
	input wire logic DEV_RESET_IN,
	// sequencer request
	input wire ras_pkg::stack_op_t OP_IN,
	input wire ras_pkg::int_level_t INT_LEVEL_IN,
	input wire logic [`PC_W-1:0] PC_IN,
	// sequencer answer
	output logic [`PC_W-1:0] PC_LOAD_OUT,
	output logic PC_LOAD_VALID_OUT,
	output logic STACK_RESET_OUT,
	// program memory fetch
	input wire logic [`PC_W-1:0] FETCH_ADDR_IN,
	input wire logic [15:0] FETCH_RAW_IN,
	output logic [15:0] FETCH_DATA_OUT,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP
);
	import ras_pkg::*;

	// entry zero is never built, pointer zero only marks the empty stack
	logic [`PC_W-1:0] stack_mem_r [1:`STACK_DEPTH];
	logic [`SP_W-1:0] return_stack_pointer_r;
	logic stack_full_flag_r;
	logic stack_underflow_flag_r;
	logic overflow_reset_option_r;
	logic [`PC_W-1:0] pc_load_r;
	logic pc_load_valid_r;
	logic stack_reset_r;
	logic [15:0] fetch_data_r;
	logic [31:0] hrdata_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic is_push, is_pop, sw_wr, ovf_hit;
	logic [`SP_W-1:0] sp_inc;
	logic [`PC_W-1:0] push_val, top_val;

	// byte lane of a top-entry register, zero when the pointer is empty
	function automatic logic [7:0] top_byte(input logic [7:0] a,
		input logic [`PC_W-1:0] v, input logic [`SP_W-1:0] sp);
		logic [23:0] w;
		w = {3'h0, v};
		top_byte = 8'h00;
		if (sp != `SP_EMPTY)
		begin
			unique case (a)
				`ADDR_TOPL: top_byte = w[7:0];
				`ADDR_TOPH: top_byte = w[15:8];
				`ADDR_TOPU: top_byte = w[23:16];
				default: top_byte = 8'h00;
			endcase
		end
	endfunction

	// decode sequencer requests
	assign is_push = (OP_IN == OP_PUSH) || (OP_IN == OP_INTACK);
	assign is_pop = (OP_IN == OP_POP);
	assign sp_inc = return_stack_pointer_r + 5'h01;
	assign ovf_hit = is_push && overflow_reset_option_r
		&& (return_stack_pointer_r == 5'h1e);
	// overflow reset stores pc+2 on the 31st push
	assign push_val = ovf_hit ? PC_IN + 21'h000002 : PC_IN;
	assign top_val = stack_mem_r[(return_stack_pointer_r == `SP_EMPTY) ?
		5'h01 : return_stack_pointer_r];
	assign sw_wr = wr_pend_r && (OP_IN == OP_NONE);

	// stack storage, private to this block and reached only here
	always_ff @(posedge CLK_IN)
	begin
		if (is_push)
		begin
			if (return_stack_pointer_r == `SP_TOP)
				stack_mem_r[`SP_TOP] <= push_val;
			else
				stack_mem_r[sp_inc] <= push_val;
		end
		else if (sw_wr && return_stack_pointer_r != `SP_EMPTY)
		begin
			unique case (wr_addr_r)
				`ADDR_TOPL: stack_mem_r[return_stack_pointer_r][7:0] <=
					HWDATA[7:0];
				`ADDR_TOPH: stack_mem_r[return_stack_pointer_r][15:8] <=
					HWDATA[7:0];
				`ADDR_TOPU: stack_mem_r[return_stack_pointer_r][20:16] <=
					HWDATA[4:0];
				default: ;
			endcase
		end
	end

	// stack pointer: async reset plus any device reset
	always_ff @(posedge CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			return_stack_pointer_r <= `SP_EMPTY;
		else if (DEV_RESET_IN || POR_IN || stack_reset_r)
			return_stack_pointer_r <= `SP_EMPTY;
		else if (is_push)
		begin
			if (ovf_hit)
				return_stack_pointer_r <= `SP_EMPTY;
			else if (return_stack_pointer_r != `SP_TOP)
				return_stack_pointer_r <= sp_inc;
		end
		else if (is_pop || OP_IN == OP_DISCARD)
		begin
			if (return_stack_pointer_r != `SP_EMPTY)
				return_stack_pointer_r <= return_stack_pointer_r - 5'h01;
		end
		else if (sw_wr && wr_addr_r == `ADDR_PTR)
			return_stack_pointer_r <= HWDATA[4:0];
	end

	// sticky flags, set wins over a software clear
	always_ff @(posedge CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			stack_full_flag_r <= 1'b0;
			stack_underflow_flag_r <= 1'b0;
		end
		else if (POR_IN)
		begin
			stack_full_flag_r <= 1'b0;
			stack_underflow_flag_r <= 1'b0;
		end
		else
		begin
			if (is_push && return_stack_pointer_r >= 5'h1e)
				stack_full_flag_r <= 1'b1;
			else if (sw_wr && wr_addr_r == `ADDR_PTR && !HWDATA[`FULL_BIT])
				stack_full_flag_r <= 1'b0;
			if ((is_pop || OP_IN == OP_DISCARD)
				&& return_stack_pointer_r == `SP_EMPTY)
				stack_underflow_flag_r <= 1'b1;
			else if (sw_wr && wr_addr_r == `ADDR_PTR && !HWDATA[`UNF_BIT])
				stack_underflow_flag_r <= 1'b0;
		end
	end

	// configuration: overflow reset option, set after reset
	always_ff @(posedge CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			overflow_reset_option_r <= `CFG_RESET;
		else if (sw_wr && wr_addr_r == `ADDR_CFG)
			overflow_reset_option_r <= HWDATA[`CFG_OVR_BIT];
	end

	// answer to the sequencer: new pc and device reset request
	always_ff @(posedge CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			pc_load_r <= `RESET_VECTOR;
			pc_load_valid_r <= 1'b1;
			stack_reset_r <= 1'b0;
		end
		else
		begin
			stack_reset_r <= ovf_hit;
			pc_load_valid_r <= 1'b1;
			if (DEV_RESET_IN || POR_IN || ovf_hit)
				pc_load_r <= `RESET_VECTOR;
			else if (OP_IN == OP_INTACK)
				pc_load_r <= (INT_LEVEL_IN == INT_LOW) ? `VEC_LOW
					: `VEC_HIGH;
			else if (is_pop)
				pc_load_r <= (return_stack_pointer_r == `SP_EMPTY) ?
					`RESET_VECTOR : top_val;
			else
				pc_load_valid_r <= 1'b0;
		end
	end

	// program fetch on its own port, zero above implemented memory
	always_ff @(posedge CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			fetch_data_r <= 16'h0000;
		else if (32'(FETCH_ADDR_IN) >= 32'(PMEM_BYTES))
			fetch_data_r <= 16'h0000;
		else
			fetch_data_r <= FETCH_RAW_IN;
	end

	// ahb-lite: capture write address, answer reads next cycle
	always_ff @(posedge CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r <= 32'h00000000;
		end
		else if (HREADYOUT)
		begin
			wr_pend_r <= HSEL && HREADY && HTRANS[1] && HWRITE;
			wr_addr_r <= HADDR[7:0];
			if (HSEL && HREADY && HTRANS[1] && !HWRITE)
			begin
				unique case (HADDR[7:0])
					`ADDR_PTR: hrdata_r <= {24'h0, stack_full_flag_r,
						stack_underflow_flag_r, 1'b0,
						return_stack_pointer_r};
					`ADDR_CFG: hrdata_r <= {31'h0, overflow_reset_option_r};
					default: hrdata_r <= {24'h0, top_byte(HADDR[7:0],
						top_val, return_stack_pointer_r)};
				endcase
			end
		end
	end

	// stall a register write while the sequencer owns the stack
	assign HREADYOUT = !(wr_pend_r && OP_IN != OP_NONE);
	assign HRDATA = hrdata_r;
	assign HRESP = 1'b0;
	assign PC_LOAD_OUT = pc_load_r;
	assign PC_LOAD_VALID_OUT = pc_load_valid_r;
	assign STACK_RESET_OUT = stack_reset_r;
	assign FETCH_DATA_OUT = fetch_data_r;
	// the latch registers live in the core and have no path here

	// assertions
	push_bump_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(is_push && !ovf_hit && return_stack_pointer_r < `SP_TOP
		&& !DEV_RESET_IN && !POR_IN && !stack_reset_r)
		|=> return_stack_pointer_r == $past(return_stack_pointer_r) + 5'h01)
		else $error("push did not increment pointer");
	pop_drop_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(is_pop && return_stack_pointer_r != `SP_EMPTY && !DEV_RESET_IN
		&& !POR_IN && !stack_reset_r)
		|=> return_stack_pointer_r == $past(return_stack_pointer_r) - 5'h01)
		else $error("pop did not decrement pointer");
	underflow_pc_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(is_pop && return_stack_pointer_r == `SP_EMPTY && !POR_IN
		&& !DEV_RESET_IN) |=> stack_underflow_flag_r && pc_load_r == 21'h0
		&& return_stack_pointer_r == `SP_EMPTY)
		else $error("empty pop mishandled");
	full_set_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(is_push && return_stack_pointer_r == 5'h1e && !POR_IN)
		|=> stack_full_flag_r)
		else $error("full flag not set");
	ovf_reset_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		ovf_hit |=> stack_reset_r && return_stack_pointer_r == `SP_EMPTY)
		else $error("overflow reset missing");
	sat_top_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(is_push && return_stack_pointer_r == `SP_TOP && !DEV_RESET_IN
		&& !POR_IN && !stack_reset_r) |=> return_stack_pointer_r == `SP_TOP)
		else $error("pointer left top");
	vector_sel_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(OP_IN == OP_INTACK && INT_LEVEL_IN == INT_LOW && !ovf_hit
		&& !DEV_RESET_IN && !POR_IN) |=> pc_load_r == `VEC_LOW)
		else $error("wrong low vector");
	fetch_zero_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(32'(FETCH_ADDR_IN) >= 32'(PMEM_BYTES)) |=> fetch_data_r == 16'h0)
		else $error("fetch past memory not zero");
	dev_reset_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		DEV_RESET_IN |=> return_stack_pointer_r == `SP_EMPTY
		&& pc_load_r == `RESET_VECTOR)
		else $error("device reset not honoured");
	// vectors, stored values, register reads and sticky flags
	high_vector_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(OP_IN == OP_INTACK && INT_LEVEL_IN != INT_LOW && !ovf_hit
		&& !DEV_RESET_IN && !POR_IN) |=> pc_load_r == `VEC_HIGH)
		else $error("wrong high vector");
	push_store_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(is_push && !ovf_hit && return_stack_pointer_r < `SP_TOP
		&& !DEV_RESET_IN && !POR_IN && !stack_reset_r)
		|=> stack_mem_r[return_stack_pointer_r] == $past(PC_IN))
		else $error("pushed pc not stored");
	ovf_store_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		ovf_hit |=> stack_mem_r[`SP_TOP] == $past(PC_IN) + 21'h000002)
		else $error("overflow push did not store pc plus two");
	pop_load_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(is_pop && return_stack_pointer_r != `SP_EMPTY && !DEV_RESET_IN
		&& !POR_IN) |=> pc_load_r == $past(top_val) && pc_load_valid_r)
		else $error("pop loaded wrong pc");
	load_idle_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(OP_IN == OP_NONE && !DEV_RESET_IN && !POR_IN)
		|=> !pc_load_valid_r)
		else $error("pc load without request");
	ptr_write_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(sw_wr && wr_addr_r == `ADDR_PTR && !DEV_RESET_IN && !POR_IN
		&& !stack_reset_r) |=> {27'h0, return_stack_pointer_r}
		== ($past(HWDATA) & 32'h0000001f))
		else $error("pointer write lost");
	ptr_read_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(HSEL && HREADY && HREADYOUT && HTRANS[1] && !HWRITE
		&& HADDR[7:0] == `ADDR_PTR) |=> hrdata_r[4:0]
		== $past(return_stack_pointer_r) && hrdata_r[5] == 1'b0
		&& hrdata_r[7] == $past(stack_full_flag_r))
		else $error("pointer read wrong");
	top_guard_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(HSEL && HREADY && HREADYOUT && HTRANS[1] && !HWRITE
		&& return_stack_pointer_r == `SP_EMPTY
		&& HADDR[7:0] == `ADDR_TOPL) |=> hrdata_r == 32'h00000000)
		else $error("empty stack top read not zero");
	full_hold_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(stack_full_flag_r && !POR_IN
		&& !(sw_wr && wr_addr_r == `ADDR_PTR)) |=> stack_full_flag_r)
		else $error("full flag dropped by itself");
	unf_hold_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(stack_underflow_flag_r && !POR_IN
		&& !(sw_wr && wr_addr_r == `ADDR_PTR)) |=> stack_underflow_flag_r)
		else $error("underflow flag dropped by itself");
	por_clear_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		POR_IN |=> !stack_full_flag_r && !stack_underflow_flag_r
		&& return_stack_pointer_r == `SP_EMPTY)
		else $error("power-on reset left state");
	fetch_pass_a: assert property
		(@(posedge CLK_IN) disable iff (!RSTN_IN)
		(32'(FETCH_ADDR_IN) < 32'(PMEM_BYTES))
		|=> fetch_data_r == $past(FETCH_RAW_IN))
		else $error("implemented fetch altered");
	// main scenarios reached
	push_pop_c: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		is_push ##1 is_pop);
	intack_c: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		OP_IN == OP_INTACK);
	full_c: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		$rose(stack_full_flag_r));
	sw_write_c: cover property (@(posedge CLK_IN) disable iff (!RSTN_IN)
		sw_wr && wr_addr_r == `ADDR_TOPL);
endmodule
`default_nettype wire

// >>> tb/seq_model.sv
`include "ras_params.svh"
`default_nettype none
module seq_model
	import ras_pkg::*;
(
	// clock
	input wire logic clk_in,
	// requests toward the stack
	output ras_pkg::stack_op_t op_out,
	output ras_pkg::int_level_t lvl_out,
	output logic [`PC_W-1:0] pc_out,
	// program memory
	input wire logic [`PC_W-1:0] addr_in,
	output logic [15:0] raw_out
);
	// stored word is never zero, so a blanked fetch stands out
	assign raw_out = addr_in[15:0] | 16'h0001;
	// idle request at time zero
	initial
	begin
		op_out = OP_NONE;
		lvl_out = INT_NONE;
		pc_out = '0;
	end
	// one-cycle request, launched just after an edge
	task automatic issue(input stack_op_t op, input int_level_t lvl,
		input logic [`PC_W-1:0] pc);
		@(posedge clk_in);
		op_out <= op;
		lvl_out <= lvl;
		pc_out <= pc;
		@(posedge clk_in);
		op_out <= OP_NONE;
	endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`include "ras_params.svh"
`default_nettype none
`define CHK(n, e, g) \
	begin \
		checked++; \
		if ((g) !== (e)) \
		begin \
			errors++; \
			$display("FAIL %s exp %h got %h", n, e, g); \
		end \
	end
module testbench import ras_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	// bench state and wires
	int errors = 0;
	int checked = 0;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic por = 1'b0;
	logic dev_rst = 1'b0;
	stack_op_t op;
	int_level_t lvl;
	logic [`PC_W-1:0] pc, pc_load;
	logic [`PC_W-1:0] fa = '0;
	logic [`PC_W-1:0] fad [3] = '{21'h003ffe, 21'h004000, 21'h1ffffe};
	logic pc_valid, stk_rst, hready, hresp;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [15:0] fraw, fdata;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata, q;
	// 200 MHz core clock
	always #2.5 clk = ~clk;
	// sequencer and program memory
	seq_model seq_model_inst (.clk_in(clk), .op_out(op), .lvl_out(lvl),
		.pc_out(pc), .addr_in(fa), .raw_out(fraw));
	// stack under test, smaller program memory
	return_address_stack #(.PMEM_BYTES(16384)) return_address_stack_inst (
		.CLK_IN(clk), .RSTN_IN(rstn), .POR_IN(por), .DEV_RESET_IN(dev_rst),
		.OP_IN(op), .INT_LEVEL_IN(lvl), .PC_IN(pc), .PC_LOAD_OUT(pc_load),
		.PC_LOAD_VALID_OUT(pc_valid), .STACK_RESET_OUT(stk_rst),
		.FETCH_ADDR_IN(fa), .FETCH_RAW_IN(fraw), .FETCH_DATA_OUT(fdata),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(hresp));
	// verdict and end of run
	task automatic close_out;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// wait for the edge that samples ready high, bounded
	task automatic wait_rdy;
		int n;
		n = 0;
		#1;
		while (hready !== 1'b1)
		begin
			@(posedge clk);
			#1;
			n++;
			if (n > 50)
			begin
				errors++;
				close_out();
			end
		end
		@(posedge clk);
	endtask
	// single word transfer, address phase then data phase
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask
	// read one register and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h00000000);
		`CHK($sformatf("reg %h", a), e, q)
		`CHK("resp", 1'b0, hresp)
		`CHK("load idle", 1'b0, pc_valid)
	endtask
	// request that loads the pc, checked one edge later
	task automatic ld(input stack_op_t o, input int_level_t l,
		input logic [`PC_W-1:0] p, input logic [`PC_W-1:0] e);
		seq_model_inst.issue(o, l, p);
		#1;
		`CHK("pc load", e, pc_load)
		`CHK("load valid", 1'b1, pc_valid)
	endtask
	// main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		#1;
		`CHK("pc after reset", 21'h000000, pc_load)
		rd(`ADDR_PTR, 32'h0);
		bus(1'b1, `ADDR_TOPL, 32'hff);
		rd(`ADDR_TOPL, 32'h0);
		rd(8'h20, 32'h0);
		$display("test reset done");
		for (int i = 1; i < 4; i++)
			seq_model_inst.issue(OP_PUSH, INT_NONE, 21'h100000 + 21'(2 * i));
		rd(`ADDR_PTR, 32'h3);
		rd(`ADDR_TOPL, 32'h6);
		rd(`ADDR_TOPU, 32'h10);
		ld(OP_POP, INT_NONE, 21'h0, 21'h100006);
		rd(`ADDR_PTR, 32'h2);
		seq_model_inst.issue(OP_DISCARD, INT_NONE, 21'h0);
		rd(`ADDR_PTR, 32'h1);
		$display("test push pop done");
		ld(OP_INTACK, INT_HIGH, 21'h00abcd, `VEC_HIGH);
		ld(OP_INTACK, INT_LOW, 21'h012346, `VEC_LOW);
		rd(`ADDR_PTR, 32'h3);
		rd(`ADDR_TOPH, 32'h23);
		// top entry replaced while no request is in flight
		bus(1'b1, `ADDR_TOPL, 32'h34);
		bus(1'b1, `ADDR_TOPH, 32'h12);
		bus(1'b1, `ADDR_TOPU, 32'h1f);
		ld(OP_POP, INT_NONE, 21'h0, 21'h1f1234);
		ld(OP_POP, INT_NONE, 21'h0, 21'h00abcd);
		ld(OP_POP, INT_NONE, 21'h0, 21'h100002);
		ld(OP_POP, INT_NONE, 21'h0, 21'h000000);
		rd(`ADDR_PTR, 32'h40);
		bus(1'b1, `ADDR_PTR, 32'h0);
		rd(`ADDR_PTR, 32'h0);
		$display("test top entry done");
		bus(1'b1, `ADDR_CFG, 32'h0);
		for (int i = 0; i < 32; i++)
			seq_model_inst.issue(OP_PUSH, INT_NONE, 21'(2 * i));
		rd(`ADDR_PTR, 32'h9f);
		rd(`ADDR_TOPL, 32'h3e);
		@(posedge clk);
		dev_rst <= 1'b1;
		@(posedge clk);
		dev_rst <= 1'b0;
		rd(`ADDR_PTR, 32'h80);
		@(posedge clk);
		por <= 1'b1;
		@(posedge clk);
		por <= 1'b0;
		rd(`ADDR_PTR, 32'h0);
		bus(1'b1, `ADDR_CFG, 32'h1);
		bus(1'b1, `ADDR_PTR, 32'h1e);
		seq_model_inst.issue(OP_PUSH, INT_NONE, 21'h000200);
		#1;
		`CHK("stack reset", 1'b1, stk_rst)
		rd(`ADDR_PTR, 32'h80);
		bus(1'b1, `ADDR_PTR, 32'h9f);
		rd(`ADDR_TOPL, 32'h2);
		$display("test overflow done");
		foreach (fad[i])
		begin
			@(posedge clk);
			fa <= fad[i];
			@(posedge clk);
			#1;
			`CHK("fetch", fad[i] < 16384 ? fad[i][15:0] | 16'h1 : 16'h0, fdata)
		end
		$display("test fetch done");
		close_out();
	end
endmodule
`default_nettype wire
